/* hw/usb_twi_pkg.sv */
// Notes on behaviour
// - Wakeup control register resets to 08H
// - Bit 3 sets forced D- level
// - Bit 2 sets forced D+ level
// - Bit 1 selects forced levels for driver
// - Bit 0 drives forced or buffer levels onto pins
// - Timer: 7 bits low-speed, 6 bits high-speed
// - Timer counts system clock or USB clock
// - High-speed start on reserved EOP event
// - Low-speed start on SYNC, reset, resume
// - Any overflow raises timer interrupt and flag
// - Low-speed overflow sets watchdog error, stops clock
// - Fixed priority, vectors 0006H to 000EH
// - Token EOP interrupt unless address mismatches
// - Data EOP interrupt regardless of errors
// - Early data interrupt on ID 11B
// - Transmit EOP raises transmit interrupt
// - J-to-K or SE0 raises bus activity interrupt
// - Reservation bits choose start; reset 01H
package usb_twi_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] ADDR_WAKEUP_CTRL = 16'hFF6A;
    localparam logic [15:0] ADDR_TIMER_RESV = 16'hFF6C;
    localparam logic [7:0] WAKEUP_CTRL_RESET = 8'h08;
    localparam logic [7:0] TIMER_RESV_RESET = 8'h01;
    localparam int WAKE_BIT_OUT = 0;
    localparam int WAKE_BIT_FIXED_EN = 1;
    localparam int WAKE_BIT_DPLUS = 2;
    localparam int WAKE_BIT_DMINUS = 3;
    localparam int RESV_BIT_SETUP_OUT = 0;
    localparam int RESV_BIT_TX = 1;

    // ==========================================
    // Timer
    localparam int TIMER_LS_WIDTH = 7;
    localparam int TIMER_HS_WIDTH = 6;

    // ==========================================
    // Interrupts, index is priority (0 highest)
    localparam int IRQ_COUNT = 5;
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_TOKEN = 1;
    localparam int IRQ_DATA = 2;
    localparam int IRQ_TX = 3;
    localparam int IRQ_BUS = 4;
    localparam logic [15:0] VECTOR_BASE = 16'h0006;
    localparam logic [15:0] VECTOR_STEP = 16'h0002;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int IDLE_BEFORE_WAKE_MS = 5;
    localparam int IDLE_BEFORE_WAKE_CYCLES = IDLE_BEFORE_WAKE_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic token_eop;
        logic addr_match;
        logic setup_out_ok;
        logic setup_rx;
        logic data_rx_eop;
        logic id_detect_11;
        logic pkt_tx_eop;
        logic tx_data_ok;
        logic sync_detect;
        logic reset_resume;
    } usb_events_t;

    typedef struct packed {
        logic dminus_force_level;
        logic dplus_force_level;
        logic fixed_level_en;
        logic wakeup_out;
    } wakeup_ctrl_t;

    typedef struct packed {
        logic start_after_tx;
        logic start_after_setup_out;
    } timer_resv_t;

endpackage

/* hw/sync_2ff.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_2ff
    import usb_twi_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg;

    // ==========================================
    // Two stages, first read only by second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage_reg <= async_in;
            sync_out <= stage_reg;
        end
    end

endmodule
`default_nettype wire

/* hw/usb_timer_core.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_timer_core
    import usb_twi_pkg::*;
#(
    parameter int WIDTH = TIMER_LS_WIDTH
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic start,
    input wire logic start_hs,
    input wire logic stop,
    input wire logic tick,
    // Status
    output logic running,
    output logic hs_mode,
    output logic [WIDTH-1:0] count,
    output logic overflow
);

    logic [WIDTH-1:0] limit;

    assign limit = hs_mode ? {1'b0, {(WIDTH-1){1'b1}}} : {WIDTH{1'b1}};

    // ==========================================
    // Counter; a restart wins over everything
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            running <= 1'b0;
            hs_mode <= 1'b0;
            count <= '0;
            overflow <= 1'b0;
        end
        else
        begin
            overflow <= 1'b0;
            if (start)
            begin
                running <= 1'b1;
                hs_mode <= start_hs;
                count <= '0;
            end
            else if (stop)
            begin
                running <= 1'b0;
            end
            else if (running && tick)
            begin
                if (count == limit)
                begin
                    running <= 1'b0;
                    count <= '0;
                    overflow <= 1'b1;
                end
                else
                begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* hw/usb_timer_wakeup_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_timer_wakeup_irq
    import usb_twi_pkg::*;
#(
    parameter int IDLE_WAKE_CYCLES = IDLE_BEFORE_WAKE_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // CPU register access
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    // Packet engine events and controls
    input wire usb_events_t evt,
    input wire logic early_rx_irq_en,
    input wire logic timer_stop,
    input wire logic wd_err_clear,
    // Bus pins and recovered clock
    input wire logic dplus_in,
    input wire logic dminus_in,
    input wire logic usb_clk_in,
    // Transmit buffer
    input wire logic tx_buf_dp,
    input wire logic tx_buf_dm,
    input wire logic tx_buf_drive,
    // USB driver
    output logic dplus_tx_line,
    output logic dminus_tx_line,
    output logic line_oe_n,
    // Interrupt controller side
    input wire logic [IRQ_COUNT-1:0] irq_mask,
    input wire logic [IRQ_COUNT-1:0] irq_clear,
    output logic [IRQ_COUNT-1:0] irq_pulse,
    output logic [IRQ_COUNT-1:0] irq_flags,
    output logic irq_request,
    output logic [15:0] irq_vector,
    // Status
    output logic clock_watchdog_err,
    output logic usb_clk_stop,
    output logic [TIMER_LS_WIDTH-1:0] timer_count,
    output logic bus_idle_ok
);

    wakeup_ctrl_t wake_reg;
    timer_resv_t resv_reg;
    logic [2:0] pins_sync;
    logic dp_s;
    logic dm_s;
    logic uclk_s;
    logic uclk_d_reg;
    logic uclk_rise;
    logic [1:0] line_prev_reg;
    logic is_j_prev;
    logic is_k_now;
    logic is_se0_now;
    logic is_se0_prev;
    logic hs_start;
    logic ls_start;
    logic tmr_running;
    logic tmr_hs;
    logic tmr_ovf;
    logic [TIMER_LS_WIDTH-1:0] tmr_count;
    logic [IRQ_COUNT-1:0] irq_set;
    logic [IRQ_COUNT-1:0] pend;
    logic [15:0] vector_next;
    logic [31:0] idle_cnt_reg;

    // ==========================================
    // Pin synchronisers
    sync_2ff #(.WIDTH(3)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({usb_clk_in, dminus_in, dplus_in}),
        .sync_out(pins_sync)
    );
    assign dp_s = pins_sync[0];
    assign dm_s = pins_sync[1];
    assign uclk_s = pins_sync[2];
    assign uclk_rise = uclk_s && !uclk_d_reg;

    // ==========================================
    // Register writes
    // Wakeup control reset value
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_reg <= wakeup_ctrl_t'(WAKEUP_CTRL_RESET[3:0]);
        end
        else if (cpu_wr && cpu_addr == ADDR_WAKEUP_CTRL)
        begin
            wake_reg <= wakeup_ctrl_t'(cpu_wdata[3:0]);
        end
    end

    // SETUP reception reloads 01H, wins over write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            resv_reg <= timer_resv_t'(TIMER_RESV_RESET[1:0]);
        end
        else if (evt.setup_rx)
        begin
            resv_reg <= timer_resv_t'(TIMER_RESV_RESET[1:0]);
        end
        else if (cpu_wr && cpu_addr == ADDR_TIMER_RESV)
        begin
            resv_reg <= timer_resv_t'(cpu_wdata[1:0]);
        end
    end

    // Unmapped addresses read zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_rdata <= 8'h00;
        end
        else if (cpu_rd)
        begin
            case (cpu_addr)
                ADDR_WAKEUP_CTRL: cpu_rdata <= {4'h0, wake_reg};
                ADDR_TIMER_RESV: cpu_rdata <= {6'h00, resv_reg};
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // Driver path
    // Forced levels or transmit buffer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dplus_tx_line <= 1'b0;
            dminus_tx_line <= 1'b1;
        end
        else if (wake_reg.fixed_level_en)
        begin
            dplus_tx_line <= wake_reg.dplus_force_level;
            dminus_tx_line <= wake_reg.dminus_force_level;
        end
        else
        begin
            dplus_tx_line <= tx_buf_dp;
            dminus_tx_line <= tx_buf_dm;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            line_oe_n <= 1'b1;
        end
        else
        begin
            line_oe_n <= !(wake_reg.wakeup_out || tx_buf_drive);
        end
    end

    // Idle gauge for software; any non-J state restarts it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            idle_cnt_reg <= '0;
            bus_idle_ok <= 1'b0;
        end
        else if (!(dm_s && !dp_s))
        begin
            idle_cnt_reg <= '0;
            bus_idle_ok <= 1'b0;
        end
        else if (idle_cnt_reg < 32'(IDLE_WAKE_CYCLES))
        begin
            idle_cnt_reg <= idle_cnt_reg + 32'd1;
        end
        else
        begin
            bus_idle_ok <= 1'b1;
        end
    end

    // ==========================================
    // USB timer
    // Reserved EOP events start high-speed count
    assign hs_start = (resv_reg.start_after_tx && evt.pkt_tx_eop && evt.tx_data_ok)
        || (resv_reg.start_after_setup_out && evt.token_eop && evt.setup_out_ok);
    // SYNC or reset/resume starts low-speed count
    assign ls_start = evt.sync_detect || evt.reset_resume;

    // Source is clk or recovered USB clock edge
    usb_timer_core #(.WIDTH(TIMER_LS_WIDTH)) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .start(hs_start || ls_start),
        .start_hs(hs_start),
        .stop(timer_stop),
        .tick(tmr_hs ? 1'b1 : uclk_rise),
        .running(tmr_running),
        .hs_mode(tmr_hs),
        .count(tmr_count),
        .overflow(tmr_ovf)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            uclk_d_reg <= 1'b0;
            timer_count <= '0;
        end
        else
        begin
            uclk_d_reg <= uclk_s;
            timer_count <= tmr_count;
        end
    end

    // Watchdog error holds the clock stopped
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_watchdog_err <= 1'b0;
            usb_clk_stop <= 1'b0;
        end
        else if (tmr_ovf && !tmr_hs)
        begin
            clock_watchdog_err <= 1'b1;
            usb_clk_stop <= 1'b1;
        end
        else if (wd_err_clear)
        begin
            clock_watchdog_err <= 1'b0;
            usb_clk_stop <= 1'b0;
        end
    end

    // ==========================================
    // Bus state: J is D- high, K is D+ high
    assign is_j_prev = line_prev_reg == 2'b10;
    assign is_se0_prev = line_prev_reg == 2'b00;
    assign is_k_now = dp_s && !dm_s;
    assign is_se0_now = !dp_s && !dm_s;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Same SE0 value as the reset synchronisers, so no false edge
            line_prev_reg <= 2'b00;
        end
        else
        begin
            line_prev_reg <= {dm_s, dp_s};
        end
    end

    // ==========================================
    // Interrupt sources
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_TIMER] = tmr_ovf;
        irq_set[IRQ_TOKEN] = evt.token_eop && evt.addr_match;
        irq_set[IRQ_DATA] = evt.data_rx_eop || (early_rx_irq_en && evt.id_detect_11);
        irq_set[IRQ_TX] = evt.pkt_tx_eop;
        irq_set[IRQ_BUS] = (is_j_prev && is_k_now) || (is_se0_now && !is_se0_prev);
    end

    // Sticky flags; a new event beats the clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_flags <= '0;
            irq_pulse <= '0;
        end
        else
        begin
            irq_flags <= (irq_flags & ~irq_clear) | irq_set;
            irq_pulse <= irq_set;
        end
    end

    assign pend = irq_flags & ~irq_mask;

    always_comb
    begin
        vector_next = VECTOR_BASE;
        for (int i = IRQ_COUNT - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                vector_next = VECTOR_BASE + VECTOR_STEP * 16'(i);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_request <= 1'b0;
            irq_vector <= VECTOR_BASE;
        end
        else
        begin
            irq_request <= |pend;
            irq_vector <= vector_next;
        end
    end

    // ==========================================
    // Checks
    sequence s_ls_ovf;
        tmr_ovf && !tmr_hs;
    endsequence

    sequence s_err_held;
        clock_watchdog_err && usb_clk_stop;
    endsequence

    a_wakeup_reset_value: assert property (@(posedge clk)
        $rose(reset_n) |-> wake_reg == wakeup_ctrl_t'(WAKEUP_CTRL_RESET[3:0]))
        else $error("wakeup control not 08H after reset");

    a_forced_levels: assert property (@(posedge clk) disable iff (!reset_n)
        wake_reg.fixed_level_en |=> dplus_tx_line == $past(wake_reg.dplus_force_level)
        && dminus_tx_line == $past(wake_reg.dminus_force_level))
        else $error("forced levels not on driver");

    a_wakeup_drive: assert property (@(posedge clk) disable iff (!reset_n)
        wake_reg.wakeup_out |=> !line_oe_n)
        else $error("wakeup bit did not drive lines");

    a_hs_width: assert property (@(posedge clk) disable iff (!reset_n)
        tmr_hs |-> tmr_count <= 7'h3F)
        else $error("high-speed timer beyond six bits");

    a_hs_start: assert property (@(posedge clk) disable iff (!reset_n)
        hs_start |=> tmr_running && tmr_hs && tmr_count == 7'h00)
        else $error("reserved EOP did not start timer");

    a_ls_start: assert property (@(posedge clk) disable iff (!reset_n)
        ls_start && !hs_start |=> tmr_running && !tmr_hs)
        else $error("low-speed start missed");

    a_ovf_flag: assert property (@(posedge clk) disable iff (!reset_n)
        tmr_ovf |=> irq_flags[IRQ_TIMER] && irq_pulse[IRQ_TIMER])
        else $error("overflow flag not set");

    a_watchdog_err: assert property (@(posedge clk) disable iff (!reset_n)
        s_ls_ovf |=> s_err_held ##1 (s_err_held or $past(wd_err_clear)))
        else $error("watchdog error not held");

    a_token_mask: assert property (@(posedge clk) disable iff (!reset_n)
        evt.token_eop && !evt.addr_match && !irq_flags[IRQ_TOKEN] |=> !irq_pulse[IRQ_TOKEN])
        else $error("foreign token raised interrupt");

    a_early_rx: assert property (@(posedge clk) disable iff (!reset_n)
        early_rx_irq_en && evt.id_detect_11 |=> irq_flags[IRQ_DATA])
        else $error("early data interrupt missed");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        irq_flags[IRQ_BUS] && !irq_clear[IRQ_BUS] |=> irq_flags[IRQ_BUS])
        else $error("bus flag dropped without clear");

    a_top_priority: assert property (@(posedge clk) disable iff (!reset_n)
        pend[IRQ_TIMER] |=> irq_request && irq_vector == 16'h0006)
        else $error("timer not top priority");

endmodule
`default_nettype wire

/* dv/usb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
    // Line state request: 0 J, 1 K, 2 SE0
    input wire logic [1:0] bus_state,
    // Recovered clock gate, high only within frames
    input wire logic clk_run,
    // Bus pins and recovered clock
    output logic dplus_in,
    output logic dminus_in,
    output logic usb_clk_in
);
    // ==========================================
    // Bus line levels
    // J, K, SE0 levels
    always_comb
    begin
        dplus_in = (bus_state == 2'd1);
        dminus_in = (bus_state == 2'd0);
    end

    // ==========================================
    // Recovered clock
    // Slow clock, still between frames
    initial
    begin
        usb_clk_in = 1'b0;
        forever
        begin
            #333;
            if (clk_run)
                usb_clk_in = ~usb_clk_in;
            else
                usb_clk_in = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_usb_timer_wakeup_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usb_timer_wakeup_irq
    import usb_twi_pkg::*;
;
    logic clk, reset_n, cpu_wr, cpu_rd, early_rx_irq_en, timer_stop, wd_err_clear;
    logic [15:0] cpu_addr, irq_vector;
    logic [7:0] cpu_wdata, cpu_rdata;
    usb_events_t evt, ev;
    logic tx_buf_dp, tx_buf_dm, tx_buf_drive, dplus_in, dminus_in, usb_clk_in;
    logic dplus_tx_line, dminus_tx_line, line_oe_n, irq_request;
    logic [4:0] irq_mask, irq_clear, irq_pulse, irq_flags;
    logic clock_watchdog_err, usb_clk_stop, bus_idle_ok, clk_run, prev_uclk;
    logic [6:0] timer_count;
    logic [1:0] bus_state;
    int err_total, comparisons, edges;

    usb_timer_wakeup_irq #(.IDLE_WAKE_CYCLES(20)) u_usb_timer_wakeup_irq (.clk(clk),
        .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .evt(evt),
        .early_rx_irq_en(early_rx_irq_en), .timer_stop(timer_stop),
        .wd_err_clear(wd_err_clear), .dplus_in(dplus_in), .dminus_in(dminus_in),
        .usb_clk_in(usb_clk_in), .tx_buf_dp(tx_buf_dp), .tx_buf_dm(tx_buf_dm),
        .tx_buf_drive(tx_buf_drive), .dplus_tx_line(dplus_tx_line),
        .dminus_tx_line(dminus_tx_line), .line_oe_n(line_oe_n), .irq_mask(irq_mask),
        .irq_clear(irq_clear), .irq_pulse(irq_pulse), .irq_flags(irq_flags),
        .irq_request(irq_request), .irq_vector(irq_vector),
        .clock_watchdog_err(clock_watchdog_err), .usb_clk_stop(usb_clk_stop),
        .timer_count(timer_count), .bus_idle_ok(bus_idle_ok));

    usb_host_model u_usb_host_model (.bus_state(bus_state), .clk_run(clk_run),
        .dplus_in(dplus_in), .dminus_in(dminus_in), .usb_clk_in(usb_clk_in));

    // ==========================================
    // Clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever
            #5 clk = ~clk;
    end

    // Whole run is near 9k cycles, so 50k means a hang
    initial
    begin
        #500000;
        err_total++;
        close_out();
    end

    // ==========================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk);
        cpu_rd <= 1'b0;
        #1;
        check(16'(cpu_rdata), 16'(exp));
    endtask

    task automatic lines(input logic dp, input logic dm, input logic oe_n);
        wait_n(2);
        check(16'({dplus_tx_line, dminus_tx_line, line_oe_n}), 16'({dp, dm, oe_n}));
    endtask

    // Returns one ns after the edge that shows the pulse and flag
    task automatic pulse(input usb_events_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        #1;
    endtask

    task automatic clr(input logic [4:0] m);
        @(posedge clk);
        irq_clear <= m;
        @(posedge clk);
        irq_clear <= 5'h00;
        wait_n(1);
    endtask

    task automatic hs_run(input usb_events_t e);
        pulse(e);
        wait_n(64);
        check(16'(irq_flags[IRQ_TIMER]), 16'h0000);
        check(16'(timer_count), 16'h003F);
        wait_n(1);
        check(16'(irq_flags[IRQ_TIMER]), 16'h0001);
        check(16'(clock_watchdog_err), 16'h0000);
    endtask

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // Tests
    initial
    begin
        reset_n = 1'b0;
        {cpu_wr, cpu_rd, early_rx_irq_en, timer_stop, wd_err_clear, clk_run} = '0;
        {tx_buf_dp, tx_buf_dm, tx_buf_drive} = '0;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        evt = '0;
        irq_mask = 5'h00;
        irq_clear = 5'h00;
        bus_state = 2'd0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(16'({dplus_tx_line, dminus_tx_line, line_oe_n}), 16'h0003);
        rd_chk(ADDR_WAKEUP_CTRL, 8'h08);
        rd_chk(ADDR_TIMER_RESV, 8'h01);
        wr(16'hFF00, 8'h55);
        rd_chk(16'hFF00, 8'h00);
        rd_chk(ADDR_WAKEUP_CTRL, 8'h08);
        // Idle J bus after reset leaves no stray event
        check(16'(irq_flags), 16'h0000);
        $display("Test reset done");

        for (int i = 0; i < 100 && bus_idle_ok !== 1'b1; i++)
            wait_n(1);
        check(16'(bus_idle_ok), 16'h0001);
        @(posedge clk);
        tx_buf_dp <= 1'b1;
        tx_buf_drive <= 1'b1;
        lines(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        tx_buf_dp <= 1'b0;
        tx_buf_drive <= 1'b0;
        lines(1'b0, 1'b0, 1'b1);
        wr(ADDR_WAKEUP_CTRL, 8'hF0);
        rd_chk(ADDR_WAKEUP_CTRL, 8'h00);
        // Resume entry sequence, J first then K
        wr(ADDR_WAKEUP_CTRL, 8'h08);
        wr(ADDR_WAKEUP_CTRL, 8'h08);
        wr(ADDR_WAKEUP_CTRL, 8'h0A);
        wr(ADDR_WAKEUP_CTRL, 8'h0B);
        lines(1'b0, 1'b1, 1'b0);
        wr(ADDR_WAKEUP_CTRL, 8'h07);
        lines(1'b1, 1'b0, 1'b0);
        // Resume exit sequence releases the lines
        wr(ADDR_WAKEUP_CTRL, 8'h06);
        lines(1'b1, 1'b0, 1'b1);
        wr(ADDR_WAKEUP_CTRL, 8'h04);
        lines(1'b0, 1'b0, 1'b1);
        wr(ADDR_WAKEUP_CTRL, 8'h00);
        wr(ADDR_WAKEUP_CTRL, 8'h08);
        rd_chk(ADDR_WAKEUP_CTRL, 8'h08);
        $display("Test wakeup done");

        ev = '0;
        ev.token_eop = 1'b1;
        pulse(ev);
        check(16'(irq_flags), 16'h0000);
        ev.addr_match = 1'b1;
        pulse(ev);
        check(16'(irq_pulse), 16'h0002);
        wait_n(1);
        check({irq_request, irq_vector[14:0]}, 16'h8008);
        ev = '0;
        ev.data_rx_eop = 1'b1;
        pulse(ev);
        check(16'(irq_flags), 16'h0006);
        clr(5'h04);
        @(posedge clk);
        early_rx_irq_en <= 1'b1;
        ev = '0;
        ev.id_detect_11 = 1'b1;
        pulse(ev);
        check(16'(irq_flags), 16'h0006);
        ev = '0;
        ev.pkt_tx_eop = 1'b1;
        pulse(ev);
        check(16'(irq_pulse), 16'h0008);
        bus_state <= 2'd1;
        wait_n(6);
        check(16'(irq_flags), 16'h001E);
        bus_state <= 2'd0;
        wait_n(10);
        check(16'(irq_flags), 16'h001E);
        for (int i = 1; i < 5; i++)
        begin
            @(posedge clk);
            irq_mask <= 5'((1 << i) - 1);
            wait_n(2);
            check(irq_vector, 16'(16'h0006 + 16'h0002 * i));
        end
        @(posedge clk);
        irq_mask <= 5'h1F;
        wait_n(2);
        check(16'({irq_request, irq_flags}), 16'h001E);
        @(posedge clk);
        irq_mask <= 5'h00;
        $display("Test interrupts done");

        wr(ADDR_TIMER_RESV, 8'h02);
        ev = '0;
        ev.pkt_tx_eop = 1'b1;
        ev.tx_data_ok = 1'b1;
        hs_run(ev);
        wait_n(1);
        check(irq_vector, 16'h0006);
        ev = '0;
        ev.setup_rx = 1'b1;
        pulse(ev);
        rd_chk(ADDR_TIMER_RESV, 8'h01);
        clr(5'h1F);
        ev = '0;
        ev.token_eop = 1'b1;
        ev.addr_match = 1'b1;
        ev.setup_out_ok = 1'b1;
        hs_run(ev);
        // Stopped or low-speed restarted count must not overflow
        clr(5'h1F);
        pulse(ev);
        @(posedge clk);
        timer_stop <= 1'b1;
        @(posedge clk);
        timer_stop <= 1'b0;
        wait_n(70);
        check(16'(irq_flags[IRQ_TIMER]), 16'h0000);
        pulse(ev);
        ev = '0;
        ev.reset_resume = 1'b1;
        pulse(ev);
        wait_n(70);
        check(16'(irq_flags[IRQ_TIMER]), 16'h0000);
        $display("Test fast timer done");

        clr(5'h1F);
        ev = '0;
        ev.sync_detect = 1'b1;
        pulse(ev);
        clk_run <= 1'b1;
        edges = 0;
        prev_uclk = 1'b0;
        for (int i = 0; i < 20000 && clock_watchdog_err !== 1'b1; i++)
        begin
            @(posedge clk);
            if (usb_clk_in && !prev_uclk)
                edges++;
            prev_uclk = usb_clk_in;
        end
        clk_run <= 1'b0;
        #1;
        check(16'(edges >= 128 && edges <= 130), 16'h0001);
        check(16'({usb_clk_stop, irq_flags[IRQ_TIMER]}), 16'h0003);
        @(posedge clk);
        wd_err_clear <= 1'b1;
        @(posedge clk);
        wd_err_clear <= 1'b0;
        wait_n(2);
        check(16'({clock_watchdog_err, usb_clk_stop}), 16'h0000);
        clr(5'h1F);
        bus_state <= 2'd2;
        wait_n(6);
        check(16'(irq_flags[IRQ_BUS]), 16'h0001);
        bus_state <= 2'd0;
        $display("Test slow timer done");
        close_out();
    end
endmodule
`default_nettype wire
